// ==== logic/qdc_pkg.sv ====
/*
 * qdc_pkg: frame layout, load codes and power-down encodings for the
 * quad converter serial command front end.
 * assumes: shared by the top, the frame receiver and the channel store.
 */
`default_nettype none
package qdc_pkg;
    localparam int FRAME_BITS   = 24;
    localparam int DATA_BITS    = 16;
    localparam int CNT_W        = 5;
    localparam int NUM_CH       = 4;
    localparam int CH_W         = 2;
    // field positions inside the captured frame
    localparam int POS_ADDR_HI  = 23;
    localparam int POS_ADDR_LO  = 22;
    localparam int POS_LOAD_HI  = 21;
    localparam int POS_LOAD_LO  = 20;
    localparam int POS_DONTCARE = 19;
    localparam int POS_SEL_HI   = 18;
    localparam int POS_SEL_LO   = 17;
    localparam int POS_PD_FLAG  = 16;
    localparam int POS_PD_HI    = 15;
    localparam int POS_PD_LO    = 14;
    localparam logic [CNT_W-1:0] LAST_BIT = 5'h17;
    localparam logic [CNT_W-1:0] CNT_DONE = 5'h18;
    // load field codes
    localparam logic [1:0] LOAD_STORE  = 2'h0;
    localparam logic [1:0] LOAD_SINGLE = 2'h1;
    localparam logic [1:0] LOAD_SIMUL  = 2'h2;
    localparam logic [1:0] LOAD_BCAST  = 2'h3;
    // power-down output modes
    localparam logic [1:0] PD_HIZ_A    = 2'h0;
    localparam logic [1:0] PD_1K       = 2'h1;
    localparam logic [1:0] PD_100K     = 2'h2;
    localparam logic [1:0] PD_HIZ_B    = 2'h3;
    // reset values: zero code, powered up
    localparam logic [DATA_BITS-1:0] RST_CODE = 16'h0000;
    localparam logic                 RST_PD   = 1'b0;
    localparam logic [1:0]           RST_MODE = 2'h0;
    // minimum gap host keeps after the last clock edge
    localparam int GAP_NS    = 130;
    localparam int CLK_NS    = 8;
    localparam int GAP_CYC   = (GAP_NS + CLK_NS - 1) / CLK_NS;
endpackage
`default_nettype wire

// ==== logic/qdc_frame_rx.sv ====
/*
 * qdc_frame_rx: samples frame select, serial clock and data through
 * two flops each, shifts 24 bits on serial clock falling edges.
 * assumes: the serial clock is much slower than clock (64 ns vs 8 ns).
 */
`timescale 1ns/1ps
`default_nettype none
module qdc_frame_rx (
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    input  wire logic                           frame_sel_n,
    input  wire logic                           sclk,
    input  wire logic                           sdata,
    output logic                                frame_done,
    output logic [qdc_pkg::FRAME_BITS-1:0]      frame_word,
    output logic                                frame_abort
);
    typedef struct packed {
        logic [1:0]                        sel_sync;
        logic [1:0]                        clk_sync;
        logic [1:0]                        dat_sync;
        logic                              sel_d;
        logic                              clk_d;
        logic [qdc_pkg::CNT_W-1:0]         cnt;
        logic [qdc_pkg::FRAME_BITS-1:0]    shreg;
        logic                              done;
        logic                              abort;
    } qdc_rx_t;

    qdc_rx_t st;
    qdc_rx_t next_st;

    logic sel_n_s;
    logic sclk_fall;
    logic sel_fall;
    logic sel_rise;

    always_comb begin
        sel_n_s   = st.sel_sync[1];
        sclk_fall = st.clk_d & ~st.clk_sync[1];
        sel_fall  = st.sel_d & ~sel_n_s;
        sel_rise  = ~st.sel_d & sel_n_s;
        next_st = st;
        next_st.sel_sync = {st.sel_sync[0], frame_sel_n};
        next_st.clk_sync = {st.clk_sync[0], sclk};
        next_st.dat_sync = {st.dat_sync[0], sdata};
        next_st.sel_d    = sel_n_s;
        next_st.clk_d    = st.clk_sync[1];
        next_st.done     = 1'b0;
        next_st.abort    = 1'b0;
        if (sel_fall) begin
            next_st.cnt = '0;
        end else if (sel_rise) begin
            if (st.cnt != qdc_pkg::CNT_DONE) begin
                next_st.abort = 1'b1;
            end
            next_st.shreg = '0;
            next_st.cnt   = '0;
        end else if (!sel_n_s && sclk_fall
                     && st.cnt != qdc_pkg::CNT_DONE) begin
            next_st.shreg = {st.shreg[qdc_pkg::FRAME_BITS-2:0],
                             st.dat_sync[1]};
            next_st.cnt   = st.cnt + 5'h01;
            if (st.cnt == qdc_pkg::LAST_BIT) begin
                next_st.done = 1'b1;
            end
        end
        if (!rst_n) begin
            next_st = '0;
            next_st.sel_sync = 2'h3;
            next_st.sel_d    = 1'b1;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    assign frame_done  = st.done;
    assign frame_word  = st.shreg;
    assign frame_abort = st.abort;

    a_frozen_after_last: assert property (@(posedge clock) disable iff (!rst_n)
        st.cnt == qdc_pkg::CNT_DONE && !sel_rise |=> $stable(st.shreg))
        else $error("shift register moved after the last bit");
    a_idle_no_shift: assert property (@(posedge clock) disable iff (!rst_n)
        st.sel_d && sel_n_s |=> $stable(st.cnt))
        else $error("bit counter moved while frame select high");
    a_abort_clears: assert property (@(posedge clock) disable iff (!rst_n)
        sel_rise |=> st.shreg == '0 && !st.done)
        else $error("aborted frame not cleared");
endmodule
`default_nettype wire

// ==== logic/qdc_chan_store.sv ====
/*
 * qdc_chan_store: one channel's temporary buffer and converter register.
 * assumes: write strobes come from the decoder on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module qdc_chan_store (
    input  wire logic                           clock,
    input  wire logic                           rst_n,
    input  wire logic                           buf_wr,
    input  wire logic                           dac_from_frame,
    input  wire logic                           dac_from_buf,
    input  wire logic [qdc_pkg::DATA_BITS-1:0]  in_code,
    input  wire logic                           in_pd,
    input  wire logic [1:0]                     in_mode,
    output logic [qdc_pkg::DATA_BITS-1:0]       dac_code,
    output logic                                dac_pd,
    output logic [1:0]                          dac_mode
);
    typedef struct packed {
        logic [qdc_pkg::DATA_BITS-1:0] b_code;
        logic                          b_pd;
        logic [1:0]                    b_mode;
        logic [qdc_pkg::DATA_BITS-1:0] d_code;
        logic                          d_pd;
        logic [1:0]                    d_mode;
    } qdc_ch_t;

    qdc_ch_t st;
    qdc_ch_t next_st;

    always_comb begin
        next_st = st;
        if (buf_wr) begin
            next_st.b_code = in_code;
            next_st.b_pd   = in_pd;
            next_st.b_mode = in_mode;
        end
        if (dac_from_frame) begin
            next_st.d_code = in_code;
            next_st.d_pd   = in_pd;
            next_st.d_mode = in_mode;
        end else if (dac_from_buf) begin
            next_st.d_code = st.b_code;
            next_st.d_pd   = st.b_pd;
            next_st.d_mode = st.b_mode;
        end
        if (!rst_n) begin
            next_st.b_code = qdc_pkg::RST_CODE;
            next_st.b_pd   = qdc_pkg::RST_PD;
            next_st.b_mode = qdc_pkg::RST_MODE;
            next_st.d_code = qdc_pkg::RST_CODE;
            next_st.d_pd   = qdc_pkg::RST_PD;
            next_st.d_mode = qdc_pkg::RST_MODE;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    assign dac_code = st.d_code;
    assign dac_pd   = st.d_pd;
    assign dac_mode = st.d_mode;
endmodule
`default_nettype wire

// ==== logic/qdc_top.sv ====
/*
 * qdc_top: serial command front end and channel update logic of a
 * four-channel 16-bit converter.
 * assumes: address straps are static; serial pins are asynchronous.
 */
// Behaviour
// - frame starts with select low; data shifted on serial clock falls
// - after 24 bits the shift register freezes for the frame
// - upper 8 bits are control, lower 16 bits are data
// - command executes right after the 24th falling edge
// - next frame begins at next select fall; counter rearms there
// - early select rise clears shifter and discards the frame
// - bit 19 is ignored
// - bits 18:17 pick the channel
// - select codes 0..3 map to channels A..D
// - load 00 writes only the selected temporary buffer
// - load 01 writes buffer and converter register of channel
// - load 10 writes channel, others load from their buffers
// - load 11 acts regardless of address bits
// - broadcast: bit18 clear loads converters from buffers, set writes all channels
// - bit 16 set makes bits 15:14 the power-down selector
// - selector 00/11 high impedance, 01 1k, 10 100k to ground
// - buffers hold data or power-down; loads may mix both
// - converter code is straight binary 0 to 65535
// - power-up clears all registers to zero scale
`timescale 1ns/1ps
`default_nettype none
module qdc_top (
    input  wire logic                                   clock,
    input  wire logic                                   rst_n,
    input  wire logic                                   frame_sel_n,
    input  wire logic                                   sclk,
    input  wire logic                                   sdata,
    input  wire logic                                   addr_pin_hi,
    input  wire logic                                   addr_pin_lo,
    output logic [qdc_pkg::NUM_CH*qdc_pkg::DATA_BITS-1:0] dac_code,
    output logic [qdc_pkg::NUM_CH-1:0]                  dac_pd,
    output logic [qdc_pkg::NUM_CH-1:0]                  out_hiz,
    output logic [qdc_pkg::NUM_CH-1:0]                  out_pull_1k,
    output logic [qdc_pkg::NUM_CH-1:0]                  out_pull_100k,
    output logic                                        cmd_strobe,
    output logic                                        frame_abort
);
    localparam int NC = qdc_pkg::NUM_CH;
    localparam int DW = qdc_pkg::DATA_BITS;

    typedef struct packed {
        logic [1:0]        addr_sync_hi;
        logic [1:0]        addr_sync_lo;
        logic              strobe;
        logic              abort;
        logic [NC-1:0]     hiz;
        logic [NC-1:0]     p1k;
        logic [NC-1:0]     p100k;
    } qdc_top_t;

    qdc_top_t st;
    qdc_top_t next_st;

    logic                              rx_done;
    logic                              rx_abort;
    logic [qdc_pkg::FRAME_BITS-1:0]    rx_word;

    logic                              addr_ok;
    logic [1:0]                        load_code;
    logic [qdc_pkg::CH_W-1:0]          ch_sel;
    logic                              pd_flag;
    logic [1:0]                        pd_mode;
    logic [DW-1:0]                     in_code;
    logic [NC-1:0]                     buf_wr;
    logic [NC-1:0]                     dac_frame;
    logic [NC-1:0]                     dac_buf;
    logic [NC*DW-1:0]                  ch_code;
    logic [NC-1:0]                     ch_pd;
    logic [NC*2-1:0]                   ch_mode;

    qdc_frame_rx u_rx (
        .clock       (clock),
        .rst_n       (rst_n),
        .frame_sel_n (frame_sel_n),
        .sclk        (sclk),
        .sdata       (sdata),
        .frame_done  (rx_done),
        .frame_word  (rx_word),
        .frame_abort (rx_abort)
    );

    // decode of the frozen frame; bit 19 deliberately unused
    always_comb begin
        load_code = {rx_word[qdc_pkg::POS_LOAD_HI],
                     rx_word[qdc_pkg::POS_LOAD_LO]};
        ch_sel    = {rx_word[qdc_pkg::POS_SEL_HI],
                     rx_word[qdc_pkg::POS_SEL_LO]};
        pd_flag   = rx_word[qdc_pkg::POS_PD_FLAG];
        pd_mode   = {rx_word[qdc_pkg::POS_PD_HI],
                     rx_word[qdc_pkg::POS_PD_LO]};
        in_code   = rx_word[DW-1:0];
        addr_ok   = (rx_word[qdc_pkg::POS_ADDR_HI] == st.addr_sync_hi[1])
                 && (rx_word[qdc_pkg::POS_ADDR_LO] == st.addr_sync_lo[1]);
    end

    always_comb begin
        buf_wr    = '0;
        dac_frame = '0;
        dac_buf   = '0;
        if (rx_done) begin
            if (load_code == qdc_pkg::LOAD_BCAST) begin
                if (rx_word[qdc_pkg::POS_SEL_HI]) begin
                    buf_wr    = '1;
                    dac_frame = '1;
                end else begin
                    dac_buf   = '1;
                end
            end else if (addr_ok) begin
                for (int i = 0; i < NC; i++) begin
                    if (ch_sel == i[qdc_pkg::CH_W-1:0]) begin
                        buf_wr[i] = 1'b1;
                        if (load_code != qdc_pkg::LOAD_STORE) begin
                            dac_frame[i] = 1'b1;
                        end
                    end else if (load_code == qdc_pkg::LOAD_SIMUL) begin
                        dac_buf[i] = 1'b1;
                    end
                end
            end
        end
    end

    genvar g;
    generate
        for (g = 0; g < NC; g++) begin : gen_ch
            qdc_chan_store u_ch (
                .clock          (clock),
                .rst_n          (rst_n),
                .buf_wr         (buf_wr[g]),
                .dac_from_frame (dac_frame[g]),
                .dac_from_buf   (dac_buf[g]),
                .in_code        (in_code),
                .in_pd          (pd_flag),
                .in_mode        (pd_mode),
                .dac_code       (ch_code[g*DW +: DW]),
                .dac_pd         (ch_pd[g]),
                .dac_mode       (ch_mode[g*2 +: 2])
            );
        end
    endgenerate

    always_comb begin
        next_st = st;
        next_st.addr_sync_hi = {st.addr_sync_hi[0], addr_pin_hi};
        next_st.addr_sync_lo = {st.addr_sync_lo[0], addr_pin_lo};
        next_st.strobe = rx_done;
        next_st.abort  = rx_abort;
        for (int i = 0; i < NC; i++) begin
            // registered here so every output leaves a flop
            next_st.hiz[i]   = ch_pd[i]
                && (ch_mode[i*2 +: 2] == qdc_pkg::PD_HIZ_A
                 || ch_mode[i*2 +: 2] == qdc_pkg::PD_HIZ_B);
            next_st.p1k[i]   = ch_pd[i]
                && ch_mode[i*2 +: 2] == qdc_pkg::PD_1K;
            next_st.p100k[i] = ch_pd[i]
                && ch_mode[i*2 +: 2] == qdc_pkg::PD_100K;
        end
        if (!rst_n) begin
            next_st = '0;
        end
    end

    always_ff @(posedge clock) begin
        st <= next_st;
    end

    assign dac_code      = ch_code;
    assign dac_pd        = ch_pd;
    assign out_hiz       = st.hiz;
    assign out_pull_1k   = st.p1k;
    assign out_pull_100k = st.p100k;
    assign cmd_strobe    = st.strobe;
    assign frame_abort   = st.abort;

    sequence s_single_cmd;
        rx_done && addr_ok && load_code == qdc_pkg::LOAD_SINGLE
            && ch_sel == 2'h0 && !pd_flag;
    endsequence

    sequence s_bcast_reload;
        rx_done && load_code == qdc_pkg::LOAD_BCAST
            && !rx_word[qdc_pkg::POS_SEL_HI];
    endsequence

    a_single_loads_a: assert property (@(posedge clock) disable iff (!rst_n)
        s_single_cmd |=> dac_code[DW-1:0] == $past(in_code))
        else $error("single update did not load channel A");
    a_store_keeps_dac: assert property (@(posedge clock) disable iff (!rst_n)
        rx_done && load_code == qdc_pkg::LOAD_STORE |=> $stable(dac_code))
        else $error("store changed a converter register");
    a_mismatch_ignored: assert property (@(posedge clock) disable iff (!rst_n)
        rx_done && !addr_ok && load_code != qdc_pkg::LOAD_BCAST
            |=> $stable(dac_code) && $stable(dac_pd))
        else $error("unaddressed frame took effect");
    a_bcast_all: assert property (@(posedge clock) disable iff (!rst_n)
        s_bcast_reload |-> dac_buf == '1 && buf_wr == '0)
        else $error("broadcast reload did not reach all channels");
    a_bcast_no_addr: assert property (@(posedge clock) disable iff (!rst_n)
        rx_done && load_code == qdc_pkg::LOAD_BCAST |-> dac_frame != '0 || dac_buf != '0)
        else $error("broadcast ignored");
    a_simul_others: assert property (@(posedge clock) disable iff (!rst_n)
        rx_done && addr_ok && load_code == qdc_pkg::LOAD_SIMUL
            |-> $countones(dac_buf) == 3 && $countones(dac_frame) == 1)
        else $error("simultaneous update mis-steered");
    a_pd_mode_out: assert property (@(posedge clock) disable iff (!rst_n)
        ch_pd[1] && ch_mode[3:2] == qdc_pkg::PD_1K
            |=> out_pull_1k[1] && !out_hiz[1] && !out_pull_100k[1])
        else $error("power-down mode output wrong");
    a_strobe_pulse: assert property (@(posedge clock) disable iff (!rst_n)
        rx_done |=> cmd_strobe ##1 !cmd_strobe)
        else $error("command strobe not one cycle");
endmodule
`default_nettype wire

// ==== verif/qdc_host_model.sv ====
/*
 * qdc_host_model: host side of the three-wire link, sends frames of
 * 24 bits msb first with a 64 ns serial clock.
 * assumes: clock is the 8 ns system clock; bench calls the tasks.
 */
`timescale 1ns/1ps
`default_nettype none
module qdc_host_model (
    input  wire logic clock,
    output var logic  frame_sel_n,
    output var logic  sclk,
    output var logic  sdata
);
    // margin over the minimum gap so synchroniser lag never eats it
    localparam int GAP = qdc_pkg::GAP_CYC + 3;

    initial begin
        frame_sel_n = 1'b1;
        sclk        = 1'b1;
        sdata       = 1'b0;
    end

    // nbits below 24 aborts the frame; extra adds clocks after bit 24
    task automatic send(input logic [23:0] w, input int nbits,
                        input int extra);
        int i;
        @(posedge clock);
        frame_sel_n <= 1'b0;
        repeat (4) @(posedge clock);
        for (i = 0; i < nbits + extra; i++) begin
            sclk  <= 1'b1;
            sdata <= (i < nbits) ? w[23-i] : ~sdata;
            repeat (4) @(posedge clock);
            sclk <= 1'b0;
            repeat (4) @(posedge clock);
        end
        sclk  <= 1'b1;
        sdata <= ~sdata;
        repeat (GAP) @(posedge clock);
        frame_sel_n <= 1'b1;
        repeat (4) @(posedge clock);
    endtask

    // clock noise while deselected; n even leaves sclk high
    task automatic idle(input int n);
        int i;
        for (i = 0; i < n; i++) begin
            @(posedge clock);
            sclk  <= ~sclk;
            sdata <= ~sdata;
            repeat (3) @(posedge clock);
        end
    endtask
endmodule
`default_nettype wire

// ==== verif/qdc_top_test.sv ====
/*
 * qdc_top_test: self-checking bench for qdc_top with a channel model.
 * assumes: qdc_host_model drives the link; address straps fixed at 2.
 */
`timescale 1ns/1ps
`default_nettype none
module qdc_top_test;
    localparam logic [1:0] AD = 2'h2;
    localparam logic [1:0] NA = 2'h1;
    logic        clock;
    logic        rst_n;
    logic        addr_hi;
    logic        addr_lo;
    wire logic   frame_sel_n;
    wire logic   sclk;
    wire logic   sdata;
    logic [63:0] dac_code;
    logic [3:0]  dac_pd;
    logic [3:0]  out_hiz;
    logic [3:0]  out_pull_1k;
    logic [3:0]  out_pull_100k;
    logic        cmd_strobe;
    logic        frame_abort;
    // model entries are {pd, mode, code}
    logic [18:0] bm [4];
    logic [18:0] dm [4];
    int          n_fail = 0;
    int          checks = 0;
    int          n_strobe = 0;
    int          n_abort = 0;
    int          n_late = 0;

    qdc_top qdc_top_i (
        .clock(clock), .rst_n(rst_n), .frame_sel_n(frame_sel_n),
        .sclk(sclk), .sdata(sdata), .addr_pin_hi(addr_hi),
        .addr_pin_lo(addr_lo), .dac_code(dac_code), .dac_pd(dac_pd),
        .out_hiz(out_hiz), .out_pull_1k(out_pull_1k),
        .out_pull_100k(out_pull_100k), .cmd_strobe(cmd_strobe),
        .frame_abort(frame_abort)
    );
    qdc_host_model qdc_host_model_i (
        .clock(clock), .frame_sel_n(frame_sel_n), .sclk(sclk),
        .sdata(sdata)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        if (cmd_strobe === 1'b1) begin
            n_strobe++;
            if (frame_sel_n !== 1'b0) n_late++;
        end
        if (frame_abort === 1'b1) n_abort++;
    end

    task automatic fail(input string m);
        n_fail++;
        $display("wrong value at %0t: %s", $time, m);
    endtask
    task automatic chk_code(input logic [15:0] g, input logic [15:0] e);
        checks++;
        if (g !== e) fail($sformatf("code %h, expected %h", g, e));
    endtask
    task automatic chk_flag(input logic [3:0] g, input logic [3:0] e);
        checks++;
        if (g !== e) fail($sformatf("flags %b, expected %b", g, e));
    endtask
    task automatic chk_num(input int g, input int e);
        checks++;
        if (g != e) fail($sformatf("count %0d, expected %0d", g, e));
    endtask

    function automatic logic [23:0] mk(input logic [1:0] ad, ld, sel,
                                       input logic pd,
                                       input logic [15:0] d);
        return {ad, ld, 1'b0, sel, pd, d};
    endfunction

    task automatic apply(input logic [23:0] w);
        logic [18:0] e;
        int          k;
        e = {w[16], w[15:14], w[15:0]};
        k = w[18:17];
        if (w[21:20] == qdc_pkg::LOAD_BCAST) begin
            for (k = 0; k < 4; k++) begin
                if (w[18]) bm[k] = e;
                dm[k] = bm[k];
            end
        end else if (w[23:22] == AD) begin
            bm[k] = e;
            if (w[21:20] == qdc_pkg::LOAD_SINGLE) dm[k] = e;
            if (w[21:20] == qdc_pkg::LOAD_SIMUL) dm = bm;
        end
    endtask

    task automatic check_all();
        logic [3:0] pd, hz, k1, k100;
        logic [1:0] m;
        int         k;
        for (k = 0; k < 4; k++) begin
            m       = dm[k][17:16];
            pd[k]   = dm[k][18];
            hz[k]   = pd[k] && (m == qdc_pkg::PD_HIZ_A
                                || m == qdc_pkg::PD_HIZ_B);
            k1[k]   = pd[k] && m == qdc_pkg::PD_1K;
            k100[k] = pd[k] && m == qdc_pkg::PD_100K;
            chk_code(dac_code[16*k +: 16], dm[k][15:0]);
        end
        chk_flag(dac_pd, pd);
        chk_flag(out_hiz, hz);
        chk_flag(out_pull_1k, k1);
        chk_flag(out_pull_100k, k100);
    endtask

    task automatic fr(input logic [23:0] w);
        qdc_host_model_i.send(w, 24, 0);
        apply(w);
    endtask

    task automatic t_reset();
        @(posedge clock);
        rst_n <= 1'b0;
        repeat (5) @(posedge clock);
        rst_n <= 1'b1;
        bm = '{default: '0};
        dm = '{default: '0};
        repeat (4) @(posedge clock);
        check_all();
    endtask

    task automatic t_store_simul();
        fr(mk(AD, qdc_pkg::LOAD_STORE, 2'h0, 1'b0, 16'h1234));
        check_all();
        fr(mk(AD, qdc_pkg::LOAD_STORE, 2'h1, 1'b1, 16'h4000));
        fr(mk(AD, qdc_pkg::LOAD_SIMUL, 2'h2, 1'b0, 16'hffff));
        check_all();
    endtask

    task automatic t_single();
        logic [15:0] v [4];
        logic [23:0] w;
        int          k;
        v = '{16'h0000, 16'hffff, 16'h8000, 16'h7fff};
        for (k = 0; k < 4; k++) begin
            w = mk(AD, qdc_pkg::LOAD_SINGLE, k[1:0], 1'b0, v[k]);
            w[qdc_pkg::POS_DONTCARE] = k[0];
            fr(w);
            check_all();
        end
    endtask

    task automatic t_pd_modes();
        int k;
        for (k = 0; k < 4; k++) begin
            fr(mk(AD, qdc_pkg::LOAD_SINGLE, k[1:0], 1'b1,
                  {k[1:0], 14'h0155}));
            check_all();
        end
    endtask

    task automatic t_addr();
        int s0;
        s0 = n_strobe;
        fr(mk(NA, qdc_pkg::LOAD_SINGLE, 2'h0, 1'b0, 16'h0abc));
        check_all();
        chk_num(n_strobe - s0, 1);
        fr(mk(NA, qdc_pkg::LOAD_BCAST, 2'h2, 1'b0, 16'h5a5a));
        check_all();
        fr(mk(AD, qdc_pkg::LOAD_STORE, 2'h0, 1'b0, 16'h0007));
        fr(mk(AD, qdc_pkg::LOAD_STORE, 2'h3, 1'b1, 16'h8000));
        fr(mk(NA, qdc_pkg::LOAD_BCAST, 2'h1, 1'b1, 16'hffff));
        check_all();
    endtask

    task automatic t_abort();
        logic [23:0] w;
        int          s0, a0;
        s0 = n_strobe;
        a0 = n_abort;
        w  = mk(AD, qdc_pkg::LOAD_SINGLE, 2'h1, 1'b0, 16'h3c3c);
        qdc_host_model_i.send(w, 12, 0);
        qdc_host_model_i.send(w, 23, 0);
        check_all();
        fr(w);
        check_all();
        chk_num(n_abort - a0, 2);
        chk_num(n_strobe - s0, 1);
    endtask

    task automatic t_extra();
        logic [23:0] w;
        int          s0;
        s0 = n_strobe;
        w  = mk(AD, qdc_pkg::LOAD_SIMUL, 2'h3, 1'b0, 16'hc003);
        qdc_host_model_i.send(w, 24, 5);
        apply(w);
        check_all();
        chk_num(n_strobe - s0, 1);
        chk_num(n_late, 0);
    endtask

    // enough deselected falls to finish a frame if they were counted
    task automatic t_idle();
        int s0;
        s0 = n_strobe;
        qdc_host_model_i.idle(60);
        chk_num(n_strobe - s0, 0);
        check_all();
        fr(mk(AD, qdc_pkg::LOAD_SINGLE, 2'h0, 1'b0, 16'ha5c3));
        check_all();
    endtask

    task automatic results();
        $display("checks %0d, mismatches %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    initial begin
        rst_n   <= 1'b0;
        addr_hi <= AD[1];
        addr_lo <= AD[0];
        t_reset();
        t_store_simul();
        t_single();
        t_pd_modes();
        t_addr();
        t_abort();
        t_extra();
        t_idle();
        t_reset();
        results();
    end

    // run needs about 4800 cycles; allow several times that
    initial begin
        #300000;
        fail("watchdog expired");
        results();
    end
endmodule
`default_nettype wire
